// ---- src/meter_modbus_measurement_map.sv ----
/*
  Measurement register bank: per-cycle RMS/power arithmetic,
  energy integration and the read/write answer path.
  Assumes framing and CRC are handled outside; requests arrive
  decoded and answers leave as a byte stream, all on i_mclk.
*/
`timescale 1ns/10ps
`include "meter_modbus_map.svh"

module meter_modbus_measurement_map #(
  parameter int          ACC_W    = 48,
  parameter logic [15:0] PT_RATIO = 16'h0001,
  parameter logic [15:0] CT_RATIO = 16'h0001
) (
  // Clock and reset
  input  wire logic               i_mclk,
  input  wire logic               i_rst_n,
  // Sample front end
  input  wire meter_pkg::sample_t i_sample,
  input  wire logic               i_cycle_end,
  input  wire logic               i_reactive_leading,
  // Configuration
  input  wire logic [7:0]         i_dev_addr,
  input  wire logic               i_write_enable,
  // Decoded request
  input  wire logic               i_req_valid,
  input  wire meter_pkg::req_t    i_req,
  output logic                    o_req_ready,
  // Answer byte stream
  output logic                    o_tx_valid,
  output logic [7:0]              o_tx_data,
  output logic                    o_tx_last,
  input  wire logic               i_tx_ready,
  // Accepted single-register writes
  output logic                    o_nv_wr,
  output logic [15:0]             o_nv_addr,
  output logic [15:0]             o_nv_data
);
  import meter_pkg::*;

  if (ACC_W < 40 || ACC_W > 64) begin : g_chk
    $error("ACC_W must lie in 40..64");
  end

  ////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    calc_t                    calc;
    logic [ACC_W-1:0]         sum_vv, sum_ii;  // Running squares
    logic signed [ACC_W-1:0]  sum_vi;          // Running products
    logic [15:0]              n;               // Samples this cycle
    logic [31:0]              clks;            // Clocks this cycle
    logic [ACC_W-1:0]         sn_vv, sn_ii;    // Closed cycle
    logic signed [ACC_W-1:0]  sn_vi;
    logic [15:0]              sn_n;
    logic [31:0]              sn_clks;
    logic                     sn_lead;
    logic [31:0]              vrms, irms, pmag, freq, s, q;
    logic                     pneg;
    logic [16:0]              pf;              // Q16 ratio
    logic [31:0]              wh_imp, wh_exp, wh_lag, wh_lead;
    logic [63:0]              r_imp, r_exp, r_lag, r_lead;
    image_t                   img, txi;        // Live and frozen
    tx_t                      tx;
    req_t                     rq;
    logic [7:0]               idx, last, tbyte;
    logic                     nv_wr;
    logic [15:0]              nv_addr, nv_data;
  } st_t;

  st_t st_ff;   // Registered state
  st_t nxt_st;  // Next state

  ////////////////////////////////////////////////////////////
  // Functions
  // Bit-serial integer square root
  function automatic logic [31:0] isqrt(input logic [63:0] x);
    logic [63:0] r, b, v;
    r = '0;
    v = x;
    b = 64'h4000000000000000;
    for (int k = 0; k < 32; k++) begin
      if (v >= r + b) begin
        v = v - (r + b);
        r = (r >> 1) + b;
      end else begin
        r = r >> 1;
      end
      b = b >> 2;
    end
    return r[31:0];
  endfunction : isqrt

  // Unsigned Q16 fixed point to single precision, truncating
  function automatic logic [31:0] to_float(input logic sgn,
                                           input logic [95:0] q);
    logic [95:0] nrm;
    int          m;
    m = 0;
    for (int k = 0; k < 96; k++) begin
      if (q[k]) m = k;
    end
    nrm = q << (95 - m);
    if (q == '0) return 32'h0000_0000;
    return {sgn, 8'(m + 111), nrm[94:72]};
  endfunction : to_float

  // Whole units plus carried remainder after one increment
  function automatic logic [95:0] e_step(input logic [31:0] wh,
                                         input logic [63:0] rem,
                                         input logic [63:0] inc);
    logic [64:0] sum;
    logic [64:0] whole;
    sum   = {1'b0, rem} + {1'b0, inc};
    whole = sum / 65'(`E_UNIT);
    return {wh + whole[31:0], 64'(sum % 65'(`E_UNIT))};
  endfunction : e_step

  // Register read decode; floats low word first
  function automatic logic [15:0] rd_word(input image_t m,
                                          input logic [15:0] a);
    case (a)
      `REG_P_VOLT:         return m.p_volt[15:0];
      `REG_P_VOLT + 16'h1: return m.p_volt[31:16];
      `REG_P_CURR:         return m.p_curr[15:0];
      `REG_P_CURR + 16'h1: return m.p_curr[31:16];
      `REG_P_PWR:          return m.p_pwr[15:0];
      `REG_P_PWR + 16'h1:  return m.p_pwr[31:16];
      `REG_P_VAR:          return m.p_var[15:0];
      `REG_P_VAR + 16'h1:  return m.p_var[31:16];
      `REG_P_VA:           return m.p_va[15:0];
      `REG_P_VA + 16'h1:   return m.p_va[31:16];
      `REG_P_PF:           return m.p_pf[15:0];
      `REG_P_PF + 16'h1:   return m.p_pf[31:16];
      `REG_P_FREQ:         return m.p_freq[15:0];
      `REG_P_FREQ + 16'h1: return m.p_freq[31:16];
      `REG_P_IMP:          return m.p_imp[15:0];
      `REG_P_IMP + 16'h1:  return m.p_imp[31:16];
      `REG_P_EXP:          return m.p_exp[15:0];
      `REG_P_EXP + 16'h1:  return m.p_exp[31:16];
      `REG_P_LAG:          return m.p_lag[15:0];
      `REG_P_LAG + 16'h1:  return m.p_lag[31:16];
      `REG_P_LEAD:         return m.p_lead[15:0];
      `REG_P_LEAD + 16'h1: return m.p_lead[31:16];
      `REG_S_VOLT:         return m.s_volt;
      `REG_S_CURR:         return m.s_curr;
      `REG_S_PWR:          return m.s_pwr;
      `REG_S_VAR:          return m.s_var;
      `REG_S_VA:           return m.s_va;
      `REG_S_PF:           return m.s_pf;
      `REG_S_FREQ:         return m.s_freq;
      `REG_S_IMP:          return m.s_imp[31:16];
      `REG_S_IMP + 16'h1:  return m.s_imp[15:0];
      `REG_S_EXP:          return m.s_exp[31:16];
      `REG_S_EXP + 16'h1:  return m.s_exp[15:0];
      `REG_S_LAG:          return m.s_lag[31:16];
      `REG_S_LAG + 16'h1:  return m.s_lag[15:0];
      `REG_S_LEAD:         return m.s_lead[31:16];
      `REG_S_LEAD + 16'h1: return m.s_lead[15:0];
      default:             return 16'h0000;         // Unmapped reads zero
    endcase
  endfunction : rd_word

  // Answer byte at position i (position 0 is loaded at take)
  function automatic logic [7:0] tx_gen(input image_t m,
                                        input req_t r,
                                        input logic [7:0] i);
    logic [15:0] w;
    w = rd_word(m, r.addr + 16'((i - 8'd3) >> 1));
    if (i == 8'd1) return r.func;
    if (r.func == `FN_WRITE) begin
      case (i)
        8'd2:    return r.addr[15:8];
        8'd3:    return r.addr[7:0];
        8'd4:    return r.qty[15:8];
        default: return r.qty[7:0];
      endcase
    end
    if (i == 8'd2) return {r.qty[6:0], 1'b0};
    return i[0] ? w[15:8] : w[7:0];
  endfunction : tx_gen

  ////////////////////////////////////////////////////////////
  // Next-state logic
  logic [31:0]             sq_v, sq_i;   // Sample squares
  logic signed [31:0]      pr_vi;        // Sample product
  logic [ACC_W-1:0]        vi_abs;       // Magnitude of sum
  logic [95:0]             ratio;        // Combined PT x CT
  logic [95:0]             es_a, es_b;   // Energy step results
  logic [63:0]             qq;           // Reactive square
  logic [31:0]             ps;           // Secondary watts

  always_comb begin
    nxt_st       = st_ff;
    nxt_st.nv_wr = 1'b0;
    sq_v   = 32'(i_sample.volt * i_sample.volt);
    sq_i   = 32'(i_sample.curr * i_sample.curr);
    pr_vi  = i_sample.volt * i_sample.curr;
    vi_abs = st_ff.sn_vi[ACC_W-1] ? ACC_W'(-st_ff.sn_vi) : st_ff.sn_vi;
    ratio  = 96'(PT_RATIO) * 96'(CT_RATIO);
    es_a   = '0;
    es_b   = '0;
    qq     = '0;
    ps     = st_ff.pmag / `SEC_POWER;
    // Cycle boundary closes the sums when idle with samples, and always restarts them
    if (i_cycle_end) begin
      if (st_ff.calc == ST_IDLE && st_ff.n != 16'h0000) begin
        nxt_st.sn_vv   = st_ff.sum_vv;
        nxt_st.sn_ii   = st_ff.sum_ii;
        nxt_st.sn_vi   = st_ff.sum_vi;
        nxt_st.sn_n    = st_ff.n;
        nxt_st.sn_clks = st_ff.clks;
        nxt_st.sn_lead = i_reactive_leading;
        nxt_st.calc    = ST_ROOT;
      end
      nxt_st.sum_vv = '0;
      nxt_st.sum_ii = '0;
      nxt_st.sum_vi = '0;
      nxt_st.n      = '0;
      nxt_st.clks   = 32'h0000_0001;
    end else if (st_ff.clks != 32'hffff_ffff) begin
      nxt_st.clks = st_ff.clks + 32'h1;
    end
    // Sample accumulation
    if (i_sample.valid && nxt_st.n != 16'hffff) begin
      nxt_st.sum_vv = nxt_st.sum_vv + ACC_W'(sq_v);
      nxt_st.sum_ii = nxt_st.sum_ii + ACC_W'(sq_i);
      nxt_st.sum_vi = nxt_st.sum_vi + ACC_W'(pr_vi);
      nxt_st.n      = nxt_st.n + 16'h1;
    end
    // Per-cycle arithmetic
    case (st_ff.calc)
      ST_IDLE: begin
        nxt_st.calc = nxt_st.calc;
      end
      ST_ROOT: begin
        nxt_st.vrms = isqrt(64'(st_ff.sn_vv / st_ff.sn_n));
        nxt_st.irms = isqrt(64'(st_ff.sn_ii / st_ff.sn_n));
        nxt_st.pmag = 32'(vi_abs / st_ff.sn_n);
        nxt_st.pneg = st_ff.sn_vi[ACC_W-1];
        nxt_st.freq = 32'(`FREQ_NUM / 64'(st_ff.sn_clks));
        nxt_st.calc = ST_POWER;
      end
      ST_POWER: begin
        nxt_st.s  = st_ff.vrms * st_ff.irms;
        qq        = 64'(nxt_st.s) * 64'(nxt_st.s)
                  - 64'(st_ff.pmag) * 64'(st_ff.pmag);
        nxt_st.q  = (nxt_st.s > st_ff.pmag) ? isqrt(qq) : '0;
        nxt_st.pf = (nxt_st.s == '0) ? '0 :
                    (st_ff.pmag >= nxt_st.s) ? 17'h10000 :
                    17'((64'(st_ff.pmag) << 16) / 64'(nxt_st.s));
        es_a = e_step(st_ff.pneg ? st_ff.wh_exp : st_ff.wh_imp,
                      st_ff.pneg ? st_ff.r_exp : st_ff.r_imp,
                      64'(st_ff.pmag) * 64'(st_ff.sn_clks));
        es_b = e_step(st_ff.sn_lead ? st_ff.wh_lead : st_ff.wh_lag,
                      st_ff.sn_lead ? st_ff.r_lead : st_ff.r_lag,
                      64'(nxt_st.q) * 64'(st_ff.sn_clks));
        // Sign of the cycle power picks the active accumulator, sn_lead the reactive one
        if (st_ff.pneg) {nxt_st.wh_exp, nxt_st.r_exp} = es_a;
        else            {nxt_st.wh_imp, nxt_st.r_imp} = es_a;
        if (st_ff.sn_lead) {nxt_st.wh_lead, nxt_st.r_lead} = es_b;
        else               {nxt_st.wh_lag, nxt_st.r_lag} = es_b;
        nxt_st.calc = ST_PUBLISH;
      end
      ST_PUBLISH: begin
        // Whole image replaced in one edge
        nxt_st.img.p_volt = to_float(1'b0,
          ((96'(st_ff.vrms) * 96'(PT_RATIO)) << 16) / `DIV_DECI);
        nxt_st.img.p_curr = to_float(1'b0,
          ((96'(st_ff.irms) * 96'(CT_RATIO)) << 16) / `DIV_MILLI);
        nxt_st.img.p_pwr  = to_float(st_ff.pneg,
          ((96'(st_ff.pmag) * ratio) << 16) / `DIV_POWER);
        nxt_st.img.p_var  = to_float(1'b0,
          ((96'(st_ff.q) * ratio) << 16) / `DIV_POWER);
        nxt_st.img.p_va   = to_float(1'b0,
          ((96'(st_ff.s) * ratio) << 16) / `DIV_POWER);
        nxt_st.img.p_pf   = to_float(1'b0, 96'(st_ff.pf));
        nxt_st.img.p_freq = to_float(1'b0, 96'(st_ff.freq) << 16);
        nxt_st.img.p_imp  = to_float(1'b0,
          ((96'(st_ff.wh_imp) * ratio) << 16) / `DIV_MILLI);
        nxt_st.img.p_exp  = to_float(1'b0,
          ((96'(st_ff.wh_exp) * ratio) << 16) / `DIV_MILLI);
        nxt_st.img.p_lag  = to_float(1'b0,
          ((96'(st_ff.wh_lag) * ratio) << 16) / `DIV_MILLI);
        nxt_st.img.p_lead = to_float(1'b0,
          ((96'(st_ff.wh_lead) * ratio) << 16) / `DIV_MILLI);
        nxt_st.img.s_volt = st_ff.vrms[15:0];
        nxt_st.img.s_curr = st_ff.irms[15:0];
        nxt_st.img.s_pwr  = st_ff.pneg ? 16'(-ps) : ps[15:0];
        nxt_st.img.s_var  = 16'(st_ff.q / `SEC_POWER);
        nxt_st.img.s_va   = 16'(st_ff.s / `SEC_POWER);
        nxt_st.img.s_pf   = 16'((27'(st_ff.pf) * 27'd1000) >> 16);
        nxt_st.img.s_freq = st_ff.freq[15:0];
        nxt_st.img.s_imp  = st_ff.wh_imp;
        nxt_st.img.s_exp  = st_ff.wh_exp;
        nxt_st.img.s_lag  = st_ff.wh_lag;
        nxt_st.img.s_lead = st_ff.wh_lead;
        nxt_st.calc       = ST_IDLE;
      end
      default: begin
        nxt_st.calc = ST_IDLE;
      end
    endcase
    // Request take and answer stream
    case (st_ff.tx)
      TX_IDLE: begin
        if (i_req_valid && i_req.func == `FN_READ &&
            i_req.qty != '0 && i_req.qty <= `MAX_READ) begin
          nxt_st.tx    = TX_SEND;
          nxt_st.rq    = i_req;
          nxt_st.txi   = st_ff.img;
          nxt_st.idx   = '0;
          nxt_st.last  = 8'(i_req.qty << 1) + 8'd2;
          nxt_st.tbyte = i_dev_addr;
        end else if (i_req_valid && i_req.func == `FN_WRITE &&
                     i_write_enable) begin
          nxt_st.tx      = TX_SEND;
          nxt_st.rq      = i_req;
          nxt_st.idx     = '0;
          nxt_st.last    = `WR_LAST;
          nxt_st.tbyte   = i_dev_addr;
          nxt_st.nv_wr   = 1'b1;
          nxt_st.nv_addr = i_req.addr;
          nxt_st.nv_data = i_req.qty;
        end
        // Refused writes and other codes are dropped silently
      end
      TX_SEND: begin
        if (i_tx_ready) begin
          if (st_ff.idx == st_ff.last) begin
            nxt_st.tx = TX_IDLE;
          end else begin
            nxt_st.idx   = st_ff.idx + 8'h1;
            nxt_st.tbyte = tx_gen(st_ff.txi, st_ff.rq, st_ff.idx + 8'h1);
          end
        end
      end
      default: begin
        nxt_st.tx = TX_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_ff      <= '0;
      st_ff.calc <= ST_IDLE;
      st_ff.tx   <= TX_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////
  // Outputs
  assign o_req_ready = (st_ff.tx == TX_IDLE);
  assign o_tx_valid  = (st_ff.tx == TX_SEND);
  assign o_tx_data   = st_ff.tbyte;
  assign o_tx_last   = (st_ff.tx == TX_SEND) && (st_ff.idx == st_ff.last);
  assign o_nv_wr     = st_ff.nv_wr;
  assign o_nv_addr   = st_ff.nv_addr;
  assign o_nv_data   = st_ff.nv_data;

  ////////////////////////////////////////////////////////////
  // Checks
  read_header_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_req_ready && i_req_valid && i_req.func == `FN_READ && i_req.qty != 16'h0 && i_req.qty <= `MAX_READ
    |=> (o_tx_valid && o_tx_data == $past(i_dev_addr)) ##1 (!$past(i_tx_ready) || o_tx_data == `FN_READ))
    else $error("read answer does not open with address and function");
  write_silent_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_req_ready && i_req_valid && i_req.func == `FN_WRITE && !i_write_enable
    |=> !o_tx_valid [*4])
    else $error("refused write produced an answer");
  write_gate_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_nv_wr |-> $past(i_write_enable) && $past(i_req.func) == `FN_WRITE)
    else $error("write accepted while disabled");
  other_func_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_req_ready && i_req_valid && i_req.func != `FN_READ && i_req.func != `FN_WRITE
    |=> !o_tx_valid)
    else $error("unknown function answered");
  image_atomic_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    st_ff.calc != ST_PUBLISH |=> $stable(st_ff.img))
    else $error("image changed outside publish");
  energy_mono_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    ##1 st_ff.wh_imp >= $past(st_ff.wh_imp) && st_ff.wh_exp >= $past(st_ff.wh_exp))
    else $error("energy count went backwards");
  pf_range_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    st_ff.img.s_pf <= 16'd1000 && st_ff.pf <= 17'h10000)
    else $error("power factor above one");
  var_sign_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    st_ff.calc == ST_PUBLISH |=> !st_ff.img.p_var[31] && st_ff.img.s_var == 16'($past(st_ff.q) / 32'd10000))
    else $error("reactive power signed or stale");
endmodule : meter_modbus_measurement_map

// ---- src/meter_modbus_map.svh ----
/*
  Register offsets, request codes and rate constants for the
  measurement register bank.
  Assumes the includer imports nothing else under these names.
*/
`ifndef METER_MODBUS_MAP_SVH
`define METER_MODBUS_MAP_SVH
// Primary side, two-register floats, low word first
`define REG_P_VOLT  16'h0000
`define REG_P_CURR  16'h000c
`define REG_P_PWR   16'h0012
`define REG_P_VAR   16'h001a
`define REG_P_VA    16'h0022
`define REG_P_PF    16'h002a
`define REG_P_FREQ  16'h0032
`define REG_P_IMP   16'h0034
`define REG_P_EXP   16'h0036
`define REG_P_LAG   16'h0038
`define REG_P_LEAD  16'h003a
// Secondary side, scaled integers
`define REG_S_VOLT  16'h0100
`define REG_S_CURR  16'h0106
`define REG_S_PWR   16'h0109
`define REG_S_VAR   16'h010d
`define REG_S_VA    16'h0111
`define REG_S_PF    16'h0115
`define REG_S_FREQ  16'h0119
`define REG_S_IMP   16'h011a
`define REG_S_EXP   16'h011c
`define REG_S_LAG   16'h011e
`define REG_S_LEAD  16'h0120
// Request codes and limits
`define FN_READ     8'h03
`define FN_WRITE    8'h06
`define MAX_READ    16'h007d
`define WR_LAST     8'h05
// Rates and scale divisors
`define CLK_HZ      64'd20000000
`define FREQ_NUM    (`CLK_HZ * 64'd100)
`define E_UNIT      (`CLK_HZ * 64'd36000000)
`define DIV_DECI    96'd10
`define DIV_MILLI   96'd1000
`define DIV_POWER   96'd10000000
`define SEC_POWER   32'd10000
`endif

// ---- src/meter_pkg.sv ----
/*
  Types shared by the measurement register bank.
  Assumes a 16-bit signed sample front end.
*/
package meter_pkg;
  // Decoded request: qty is count for reads, value for writes
  typedef struct packed {
    logic [7:0]  func;
    logic [15:0] addr;
    logic [15:0] qty;
  } req_t;
  // One voltage/current sample pair
  typedef struct packed {
    logic               valid;
    logic signed [15:0] volt;
    logic signed [15:0] curr;
  } sample_t;
  // Published register image
  typedef struct packed {
    logic [31:0] p_volt, p_curr, p_pwr, p_var, p_va, p_pf;
    logic [31:0] p_freq, p_imp, p_exp, p_lag, p_lead;
    logic [15:0] s_volt, s_curr, s_pwr, s_var, s_va, s_pf, s_freq;
    logic [31:0] s_imp, s_exp, s_lag, s_lead;
  } image_t;
  // Per-cycle computation sequence
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1, ST_ROOT = 4'h2, ST_POWER = 4'h4, ST_PUBLISH = 4'h8
  } calc_t;
  // Response sender
  typedef enum logic [1:0] {TX_IDLE = 2'h1, TX_SEND = 2'h2} tx_t;
endpackage : meter_pkg

// ---- testbench/meter_host_model.sv ----
/*
  Host-side byte sink for answers from the register bank.
  Assumes one clock; i_slow asks for a stalling consumer.
*/
`timescale 1ns/10ps
module meter_host_model (
  // Clock and reset
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  // Pace control and answer handshake
  input  wire logic i_slow,
  output logic      o_tx_ready
);
  logic [1:0] pace_ff;  // Stall phase counter
  // Phase counter, moved just after each edge
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pace_ff <= 2'h0;
    end else begin
      pace_ff <= (pace_ff == 2'h2) ? 2'h0 : pace_ff + 2'h1;
    end
  end
  // Ready every cycle, or one cycle in three when slow
  assign o_tx_ready = !i_slow || (pace_ff == 2'h0);
endmodule : meter_host_model

// ---- testbench/tb_meter_modbus_measurement_map.sv ----
/*
  Self-checking bench for the measurement register bank.
  Assumes the host model as byte sink and one 20 MHz clock.
*/
`timescale 1ns/10ps
`include "meter_modbus_map.svh"
module tb_meter_modbus_measurement_map;
  import meter_pkg::*;
  logic i_mclk = 1'b0, i_rst_n = 1'b0, i_cycle_end = 1'b0, i_we = 1'b0, slow = 1'b0;
  logic i_req_valid = 1'b0, o_req_ready, o_tx_valid, o_tx_last, i_tx_ready, o_nv_wr;
  logic        lead = 1'b0;  // Reactive direction sampled at cycle end
  logic [7:0]  o_tx_data;
  logic [15:0] o_nv_addr, o_nv_data, wa, wv;
  sample_t     i_sample = '0;
  req_t        i_req = '0;
  logic [8:0]  exp_q[$];  // Expected {last, byte}
  logic [15:0] exp_w[0:25];
  int          errors = 0, n_compared = 0, cycles = 0;
  logic [31:0] rng = 32'd98993;
  // Design and far-side host
  meter_modbus_measurement_map dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sample(i_sample),
    .i_cycle_end(i_cycle_end), .i_reactive_leading(lead), .i_dev_addr(8'h0c), .i_write_enable(i_we),
    .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(o_req_ready), .o_tx_valid(o_tx_valid),
    .o_tx_data(o_tx_data), .o_tx_last(o_tx_last), .i_tx_ready(i_tx_ready), .o_nv_wr(o_nv_wr),
    .o_nv_addr(o_nv_addr), .o_nv_data(o_nv_data));
  meter_host_model host (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_slow(slow), .o_tx_ready(i_tx_ready));
  always #25 i_mclk = ~i_mclk;
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test
  task automatic pb(input logic last, input logic [7:0] b);
    exp_q.push_back({last, b});
  endtask : pb
  // Hold the request until an edge sees ready high
  task automatic send(input logic [7:0] f, input logic [15:0] a, input logic [15:0] q);
    @(negedge i_mclk);
    i_req = '{func: f, addr: a, qty: q};
    i_req_valid = 1'b1;
    while (o_req_ready !== 1'b1) @(negedge i_mclk);
    @(negedge i_mclk);
    i_req_valid = 1'b0;
  endtask : send
  // Read n registers; expectation from exp_w
  // Offsets go out as listed: this host numbers registers from zero
  task automatic rd(input logic [15:0] a, input int n);
    pb(1'b0, 8'h0c);
    pb(1'b0, `FN_READ);
    pb(1'b0, 8'(2 * n));
    for (int k = 0; k < n; k++) begin
      pb(1'b0, exp_w[k][15:8]);
      pb(k == n - 1, exp_w[k][7:0]);
    end
    send(`FN_READ, a, 16'(n));
    while (exp_q.size() != 0) @(negedge i_mclk);
  endtask : rd
  // One AC cycle of 16 samples; alt flips the current on odd samples
  task automatic ac_cycle(input logic signed [15:0] v, input logic signed [15:0] c, input logic alt);
    for (int k = 0; k < 16; k++) begin
      @(negedge i_mclk);
      i_sample = '{valid: 1'b1, volt: v, curr: (alt && k[0]) ? -c : c};
    end
    @(negedge i_mclk);
    i_sample.valid = 1'b0;
    i_cycle_end = 1'b1;
    @(negedge i_mclk);
    i_cycle_end = 1'b0;
    repeat (6) @(negedge i_mclk);
  endtask : ac_cycle
  // Watcher: every accepted byte against the oldest note
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles > 20000) begin
      errors++;
      stop_test();
    end else if (i_rst_n && o_tx_valid === 1'b1 && i_tx_ready === 1'b1) begin
      if (exp_q.size() == 0) check("stray byte", {8'h00, o_tx_data}, 16'hxxxx);
      else check("answer byte", {7'h0, o_tx_last, o_tx_data}, {7'h0, exp_q.pop_front()});
    end
  end
  // Main sequence
  initial begin
    repeat (10) @(negedge i_mclk);
    i_rst_n = 1'b1;
    exp_w = '{default: 16'h0000};
    rd(`REG_P_VOLT, 2);
    ac_cycle(16'sd1000, 16'sd1000, 1'b0);
    ac_cycle(16'sd1000, 16'sd1000, 1'b0);
    exp_w[1] = 16'h42c8;
    exp_w[13] = 16'h3f80;
    rd(`REG_P_VOLT, 14);
    exp_w = '{default: 16'h0000};
    exp_w[0] = 16'h03e8;
    exp_w[6] = 16'h03e8;
    exp_w[9] = 16'h0064;
    exp_w[17] = 16'h0064;
    exp_w[21] = 16'h03e8;
    slow = 1'b1;
    rd(`REG_S_VOLT, 22);
    // Current flips sign each sample: no real power, all reactive, leading
    lead = 1'b1;
    ac_cycle(16'sd1000, 16'sd1000, 1'b1);
    exp_w = '{default: 16'h0000};
    exp_w[8] = 16'hc800;
    exp_w[9] = 16'h3dcc;
    exp_w[16] = 16'hc800;
    exp_w[17] = 16'h3dcc;
    rd(`REG_P_PWR, 26);
    for (int k = 0; k < 3; k++) begin
      rng = xs(rng);
      wa = rng[15:0];
      wv = rng[31:16];
      i_we = 1'b0;
      send(`FN_WRITE, wa, wv);
      check("nv pulse off", {15'h0, o_nv_wr}, 16'h0000);
      send(8'h10 + 8'(k), wa, wv);
      send(`FN_READ, wa, (k == 0) ? 16'h0000 : `MAX_READ + 16'(k));
      repeat (8) @(negedge i_mclk);
      i_we = 1'b1;
      pb(1'b0, 8'h0c);
      pb(1'b0, `FN_WRITE);
      pb(1'b0, wa[15:8]);
      pb(1'b0, wa[7:0]);
      pb(1'b0, wv[15:8]);
      pb(1'b1, wv[7:0]);
      send(`FN_WRITE, wa, wv);
      check("nv pulse", {15'h0, o_nv_wr}, 16'h0001);
      check("nv addr", o_nv_addr, wa);
      check("nv data", o_nv_data, wv);
      while (exp_q.size() != 0) @(negedge i_mclk);
    end
    repeat (8) @(negedge i_mclk);
    stop_test();
  end
endmodule : tb_meter_modbus_measurement_map
